//--- msm_pkg.sv
// Functional notes
// - One symbol sequence per PDU, one HARQ packet
// - Single carrier uses ordinary single-carrier mapping
// - Split across carriers only for distributed units
// - Same MCS and MIMO for all segments
// - Cut sequence into unit-sized blocks
// - First block: lowest unit, lowest carrier
// - Ascending units, then next available carrier
// - Continue until every symbol is placed
// - Tone order inside unit as single carrier
// - Units indexed separately on each carrier
// - Guard subcarriers form whole physical units
// - Contiguous units may include guard units
// - Guard data only after both sides agree
// - HARQ feedback on primary or own secondary
// - Partial carrier omits uplink-serving control
// - Allocation info on primary or per carrier
package msm_pkg;
    localparam int NUM_CARRIERS = 4;
    localparam int CAR_W = 2;
    localparam int LRU_W = 8;
    localparam int CNT_W = 16;
    localparam int TONE_W = 6;
    localparam int PRU_W = 4;
    // Symbols that fill one logical_resource_unit
    localparam logic [TONE_W-1:0] SYM_PER_LRU = 6'h30;
    localparam logic [TONE_W-1:0] TONE_LAST = SYM_PER_LRU - 6'h01;
    // Subcarriers in one physical_resource_unit
    localparam logic [7:0] SC_PER_PRU = 8'h12;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [LRU_W-1:0] LRU_ONE = 8'h01;

    typedef logic [NUM_CARRIERS-1:0] msm_mask_t;

    typedef struct packed {
        logic [CNT_W-1:0] numSymbols;
        logic distributed;
        logic [CAR_W-1:0] singleCarrier;
        logic [3:0] mcs;
        logic [2:0] mimo;
        logic [7:0] pduId;
        logic [NUM_CARRIERS-1:0][LRU_W-1:0] regionBase;
        logic [NUM_CARRIERS-1:0][LRU_W-1:0] regionLen;
    } msm_req_s;

    typedef struct packed {
        logic [31:0] data;
        logic [CAR_W-1:0] carrier;
        logic [LRU_W-1:0] logical_resource_unit;
        logic [TONE_W-1:0] tone;
        logic [7:0] pduId;
        logic [3:0] mcs;
        logic [2:0] mimo;
        logic lastSym;
    } msm_out_s;

    typedef struct packed {
        logic request;
        logic localCap;
        logic peerCap;
        logic ctrlRequest;
        logic [7:0] subcarriers;
    } msm_guard_s;

    typedef enum {MSM_IDLE, MSM_MAP} msm_state_e;

    // Lowest set carrier strictly above a start point; start -1 gives the lowest
    function automatic logic [CAR_W:0] msm_next_carrier(input msm_mask_t mask,
                                                        input int from);
        logic [CAR_W:0] pick;
        pick = {1'b1, {CAR_W{1'b0}}};
        for (int i = NUM_CARRIERS - 1; i >= 0; i--) begin
            if (mask[i] && i > from) begin
                pick = {1'b0, CAR_W'(i)};
            end
        end
        return pick;
    endfunction : msm_next_carrier
endpackage : msm_pkg

//--- msm_carrier_pick.sv
`timescale 1ns/1ps
module msm_carrier_pick (
    input msm_pkg::msm_mask_t avail,
    input wire logic [msm_pkg::CAR_W-1:0] current,
    output logic [msm_pkg::CAR_W-1:0] first,
    output logic firstNone,
    output logic [msm_pkg::CAR_W-1:0] next,
    output logic nextNone
);
    import msm_pkg::*;

    wire [CAR_W:0] firstPick;
    wire [CAR_W:0] nextPick;

    // ====================================
    // Ascending logical carrier search
    // ====================================
    assign firstPick = msm_next_carrier(avail, -1);
    assign nextPick = msm_next_carrier(avail, int'(current));
    assign first = firstPick[CAR_W-1:0];
    assign firstNone = firstPick[CAR_W];
    assign next = nextPick[CAR_W-1:0];
    assign nextNone = nextPick[CAR_W];
endmodule : msm_carrier_pick

//--- msm_guard_ctrl.sv
`timescale 1ns/1ps
module msm_guard_ctrl (
    input wire logic clock,
    input wire logic reset_n,
    input msm_pkg::msm_guard_s guard,
    output logic guardEnable,
    output logic [msm_pkg::PRU_W-1:0] guardPrus,
    output logic cruFromGuard,
    output logic guardFault
);
    import msm_pkg::*;

    logic guardEnable_reg;
    logic [PRU_W-1:0] guardPrus_reg;
    logic guardFault_reg;
    wire agreed;
    wire whole;
    wire [7:0] pruCount;
    wire enableNext;

    // ====================================
    // Guard resource admission
    // ====================================
    assign agreed = guard.request && guard.localCap && guard.peerCap;
    assign whole = (guard.subcarriers % SC_PER_PRU) == 8'h00;
    assign pruCount = guard.subcarriers / SC_PER_PRU;
    assign enableNext = agreed && whole && (pruCount != 8'h00);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            guardEnable_reg <= 1'b0;
            guardPrus_reg <= '0;
            guardFault_reg <= 1'b0;
        end else begin
            guardEnable_reg <= enableNext;
            guardPrus_reg <= enableNext ? pruCount[PRU_W-1:0] : '0;
            // Control on guard is refused and flagged
            guardFault_reg <= (guard.request && !whole) || guard.ctrlRequest;
        end
    end

    assign guardEnable = guardEnable_reg;
    assign guardPrus = guardPrus_reg;
    assign cruFromGuard = guardEnable_reg;
    assign guardFault = guardFault_reg;
endmodule : msm_guard_ctrl

//--- msm_mapper.sv
`timescale 1ns/1ps
module msm_mapper (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reqValid,
    output logic reqReady,
    input msm_pkg::msm_req_s req,
    input wire logic symValid,
    output logic symReady,
    input wire logic [31:0] symData,
    output logic outValid,
    input wire logic outReady,
    output msm_pkg::msm_out_s outSym,
    output logic allocError,
    output logic busy,
    input wire logic [msm_pkg::CAR_W-1:0] primaryCarrier,
    input msm_pkg::msm_mask_t fullyConfigured,
    input wire logic allocOnPrimary,
    output msm_pkg::msm_mask_t ulCtrlPresent,
    output msm_pkg::msm_mask_t allocInfoCarriers,
    output logic [msm_pkg::CAR_W-1:0] harqFbCarrier,
    input msm_pkg::msm_guard_s guard,
    output logic guardEnable,
    output logic [msm_pkg::PRU_W-1:0] guardPrus,
    output logic cruFromGuard,
    output logic guardFault
);
    import msm_pkg::*;

    // ====================================
    // State
    // ====================================
    msm_state_e state_reg;
    msm_state_e state_next;
    logic [CNT_W-1:0] remain_reg;
    logic [TONE_W-1:0] tone_reg;
    logic [LRU_W-1:0] lruOff_reg;
    logic [CAR_W-1:0] carrier_reg;
    msm_mask_t avail_reg;
    msm_mask_t used_reg;
    logic [NUM_CARRIERS-1:0][LRU_W-1:0] base_reg;
    logic [NUM_CARRIERS-1:0][LRU_W-1:0] len_reg;
    logic [3:0] mcs_reg;
    logic [2:0] mimo_reg;
    logic [7:0] pduId_reg;
    msm_out_s out_reg;
    logic outValid_reg;
    logic allocError_reg;
    msm_mask_t ulCtrl_reg;
    msm_mask_t allocInfo_reg;
    logic [CAR_W-1:0] harq_reg;

    // ====================================
    // Request decode
    // ====================================
    msm_mask_t reqAvail;
    msm_mask_t singleMask;
    logic [CNT_W-1:0] lruNeeded;
    logic [CNT_W-1:0] lruOffered;
    wire reqTake;
    wire reqFits;
    wire [CAR_W-1:0] firstCarrier;
    wire firstNone;
    wire [CAR_W-1:0] nextCarrier;
    wire nextNone;
    wire [CAR_W-1:0] startCarrier;
    wire [CAR_W-1:0] startPick;
    wire startNone;

    // One-hot carrier decode, shared by several masks
    function automatic msm_mask_t msm_one_hot(input logic [CAR_W-1:0] idx);
        msm_mask_t mask;
        mask = '0;
        mask[idx] = 1'b1;
        return mask;
    endfunction : msm_one_hot

    assign singleMask = msm_one_hot(req.singleCarrier);

    // Non-distributed allocations stay on one carrier
    generate
        for (genvar c = 0; c < NUM_CARRIERS; c++) begin : g_avail
            assign reqAvail[c] = req.distributed ? (req.regionLen[c] != '0)
                                                 : singleMask[c] && (req.regionLen[c] != '0);
        end
    endgenerate

    // Units offered over all usable carriers
    always_comb begin
        lruOffered = '0;
        for (int c = 0; c < NUM_CARRIERS; c++) begin
            if (reqAvail[c]) begin
                lruOffered = lruOffered + CNT_W'(req.regionLen[c]);
            end
        end
    end

    // ====================================
    // Capacity check
    // ====================================
    wire reqEmpty;
    wire reqRoom;
    wire reqAccept;

    // Whole unit count, last unit may be part filled
    assign lruNeeded = CNT_W'((32'(req.numSymbols) + 32'(TONE_LAST)) / 32'(SYM_PER_LRU));
    assign reqEmpty = (req.numSymbols == '0);
    // Too few units is refused, never wrapped
    assign reqRoom = (lruNeeded <= lruOffered);
    assign reqFits = !reqEmpty && reqRoom;
    assign reqTake = reqValid && (state_reg == MSM_IDLE);
    assign reqReady = (state_reg == MSM_IDLE);

    msm_carrier_pick u_start (
        .avail(reqAvail),
        .current(primaryCarrier),
        .first(startPick),
        .firstNone(startNone),
        .next(),
        .nextNone()
    );

    assign startCarrier = startPick;
    assign reqAccept = reqTake && reqFits && !startNone;

    // ====================================
    // Symbol placement
    // ====================================
    wire symTake;
    wire lruEnd;
    wire regionEnd;
    wire lastSym;
    wire outFree;

    msm_carrier_pick u_walk (
        .avail(avail_reg),
        .current(carrier_reg),
        .first(firstCarrier),
        .firstNone(firstNone),
        .next(nextCarrier),
        .nextNone(nextNone)
    );

    assign outFree = !outValid_reg || outReady;
    assign symReady = (state_reg == MSM_MAP) && outFree;
    assign symTake = symValid && symReady;
    assign lruEnd = (tone_reg == TONE_LAST);
    assign regionEnd = lruEnd && ((lruOff_reg + LRU_ONE) == len_reg[carrier_reg]);
    assign lastSym = (remain_reg == CNT_ONE);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MSM_IDLE: begin
                if (reqAccept) begin
                    state_next = MSM_MAP;
                end
            end
            MSM_MAP: begin
                if (symTake && lastSym) begin
                    state_next = MSM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_reg <= MSM_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Per-PDU context, fixed for every segment
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            remain_reg <= '0;
            avail_reg <= '0;
            base_reg <= '0;
            len_reg <= '0;
            mcs_reg <= '0;
            mimo_reg <= '0;
            pduId_reg <= '0;
        end else if (reqAccept) begin
            remain_reg <= req.numSymbols;
            avail_reg <= reqAvail;
            base_reg <= req.regionBase;
            len_reg <= req.regionLen;
            mcs_reg <= req.mcs;
            mimo_reg <= req.mimo;
            pduId_reg <= req.pduId;
        end else if (symTake) begin
            remain_reg <= remain_reg - CNT_ONE;
        end
    end

    // Tone, unit and carrier walk
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tone_reg <= '0;
            lruOff_reg <= '0;
            carrier_reg <= '0;
        end else if (reqTake) begin
            tone_reg <= '0;
            lruOff_reg <= '0;
            carrier_reg <= startCarrier;
        end else if (symTake) begin
            tone_reg <= lruEnd ? '0 : tone_reg + 6'h01;
            if (regionEnd) begin
                lruOff_reg <= '0;
                carrier_reg <= nextNone ? carrier_reg : nextCarrier;
            end else if (lruEnd) begin
                lruOff_reg <= lruOff_reg + LRU_ONE;
            end
        end
    end

    // ====================================
    // Output stage
    // ====================================
    msm_out_s outNext;

    always_comb begin
        outNext.data = symData;
        outNext.carrier = carrier_reg;
        outNext.logical_resource_unit = base_reg[carrier_reg] + lruOff_reg;
        outNext.tone = tone_reg;
        outNext.pduId = pduId_reg;
        outNext.mcs = mcs_reg;
        outNext.mimo = mimo_reg;
        outNext.lastSym = lastSym;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            out_reg <= '0;
            outValid_reg <= 1'b0;
        end else if (symTake) begin
            out_reg <= outNext;
            outValid_reg <= 1'b1;
        end else if (outReady) begin
            outValid_reg <= 1'b0;
        end
    end

    assign outValid = outValid_reg;
    assign outSym = out_reg;
    assign busy = (state_reg == MSM_MAP) || outValid_reg;

    // ====================================
    // Allocation error
    // ====================================
    wire errNext;

    // Held until the next descriptor is taken
    assign errNext = !reqFits || startNone;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            allocError_reg <= 1'b0;
        end else if (reqTake) begin
            allocError_reg <= errNext;
        end
    end

    assign allocError = allocError_reg;

    // ====================================
    // Carrier control placement
    // ====================================
    msm_mask_t primaryMask;
    msm_mask_t carrierMask;
    msm_mask_t usedFinal;
    msm_mask_t secondaryUsed;
    msm_mask_t allocInfoNext;
    wire primaryUsed;
    wire manySecondary;
    wire [CAR_W-1:0] harqNext;

    assign primaryMask = msm_one_hot(primaryCarrier);
    assign carrierMask = msm_one_hot(carrier_reg);
    // Final symbol's carrier counts before used_reg catches up
    assign usedFinal = used_reg | carrierMask;
    assign secondaryUsed = usedFinal & ~primaryMask;
    assign primaryUsed = (usedFinal & primaryMask) != '0;
    assign manySecondary = $countones(secondaryUsed) > 1;
    assign harqNext = (primaryUsed || manySecondary) ? primaryCarrier : carrier_reg;
    assign allocInfoNext = allocOnPrimary ? primaryMask : avail_reg;

    // Carriers touched so far by this PDU
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            used_reg <= '0;
        end else if (reqTake) begin
            used_reg <= '0;
        end else if (symTake) begin
            used_reg <= usedFinal;
        end
    end

    // Partially configured carriers drop uplink-serving control
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ulCtrl_reg <= '0;
        end else begin
            ulCtrl_reg <= fullyConfigured;
        end
    end

    // Allocation info follows primary or carrier set
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            allocInfo_reg <= '0;
        end else begin
            allocInfo_reg <= allocInfoNext;
        end
    end

    // PDU on a single secondary only answers on its own carrier; several secondaries answer on primary
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            harq_reg <= '0;
        end else if (symTake && lastSym) begin
            harq_reg <= harqNext;
        end
    end

    assign ulCtrlPresent = ulCtrl_reg;
    assign allocInfoCarriers = allocInfo_reg;
    assign harqFbCarrier = harq_reg;

    // ====================================
    // Guard resource
    // ====================================
    msm_guard_ctrl u_guard (
        .clock(clock),
        .reset_n(reset_n),
        .guard(guard),
        .guardEnable(guardEnable),
        .guardPrus(guardPrus),
        .cruFromGuard(cruFromGuard),
        .guardFault(guardFault)
    );
endmodule : msm_mapper

//--- msm_properties.sv
`timescale 1ns/1ps
// ======
// Port checker
module msm_properties (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input msm_pkg::msm_req_s req,
    input wire logic outValid,
    input wire logic outReady,
    input msm_pkg::msm_out_s outSym,
    input wire logic allocError,
    input msm_pkg::msm_mask_t fullyConfigured,
    input msm_pkg::msm_mask_t ulCtrlPresent,
    input wire logic [msm_pkg::CAR_W-1:0] primaryCarrier,
    input wire logic allocOnPrimary,
    input msm_pkg::msm_mask_t allocInfoCarriers,
    input msm_pkg::msm_guard_s guard,
    input wire logic guardEnable,
    input wire logic [msm_pkg::PRU_W-1:0] guardPrus,
    input wire logic guardFault
);
    import msm_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_zero_refused: assert property (
        reqValid && reqReady && req.numSymbols == 16'h0000 |=> allocError && reqReady)
        else $error("empty descriptor taken");
    a_uplink_ctrl: assert property (
        reset_n |=> ulCtrlPresent == $past(fullyConfigured)) else $error("uplink control wrong");
    a_output_held: assert property (
        outValid && !outReady |=> outValid && $stable(outSym)) else $error("output dropped");
    a_tone_range: assert property (
        outValid |-> outSym.tone <= TONE_LAST) else $error("tone past unit");
    a_pdu_constant: assert property (
        outValid && !outSym.lastSym |=> !outValid || ($stable(outSym.mcs)
        && $stable(outSym.mimo) && $stable(outSym.pduId))) else $error("segment scheme differs");
    a_guard_ctrl: assert property (
        guard.ctrlRequest |=> guardFault) else $error("control on guard not flagged");
    a_guard_agree: assert property (
        !(guard.request && guard.localCap && guard.peerCap) |=> !guardEnable)
        else $error("guard used without agreement");
    a_guard_whole: assert property (
        guardEnable |-> 8'(guardPrus) * SC_PER_PRU == $past(guard.subcarriers))
        else $error("guard units not whole");
    a_primary_info: assert property (
        allocOnPrimary |=> allocInfoCarriers == (msm_mask_t'(4'h1) << $past(primaryCarrier)))
        else $error("allocation info carrier wrong");

    c_last: cover property (outValid && outReady && outSym.lastSym);
    c_error: cover property ($rose(allocError));
    c_stall: cover property (outValid && !outReady);
endmodule : msm_properties

bind msm_mapper msm_properties u_msm_properties (.clock(clock), .reset_n(reset_n),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .outValid(outValid),
    .outReady(outReady), .outSym(outSym), .allocError(allocError),
    .fullyConfigured(fullyConfigured), .ulCtrlPresent(ulCtrlPresent),
    .primaryCarrier(primaryCarrier), .allocOnPrimary(allocOnPrimary),
    .allocInfoCarriers(allocInfoCarriers), .guard(guard), .guardEnable(guardEnable),
    .guardPrus(guardPrus), .guardFault(guardFault));

//--- msm_far_model.sv
`timescale 1ns/1ps
// ======
// Per-carrier mappers taking mapped symbols
module msm_far_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic outValid,
    input msm_pkg::msm_out_s outSym,
    output logic outReady
);
    import msm_pkg::*;
    msm_out_s got[$];
    always @(posedge clock) begin
        if (!reset_n) begin
            outReady <= 1'b0;
            got.delete();
        end else begin
            // Slow mode stalls every other cycle
            outReady <= slow ? !outReady : 1'b1;
            if (outValid && outReady) begin
                got.push_back(outSym);
            end
        end
    end
endmodule : msm_far_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import msm_pkg::*;
    localparam int UNIT = int'(SYM_PER_LRU);
    logic clock, reset_n, reqValid, reqReady, symValid, symReady, outValid, outReady;
    logic allocError, busy, allocOnPrimary, guardEnable, cruFromGuard, guardFault, slow;
    logic [31:0] symData;
    logic [CAR_W-1:0] primaryCarrier, harqFbCarrier;
    logic [PRU_W-1:0] guardPrus;
    msm_mask_t fullyConfigured, ulCtrlPresent, allocInfoCarriers;
    msm_req_s req;
    msm_out_s outSym;
    msm_guard_s guard;
    int n_errors = 0;
    int num_checks = 0;

    msm_mapper u_msm_mapper (.clock(clock), .reset_n(reset_n), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .symValid(symValid), .symReady(symReady),
        .symData(symData), .outValid(outValid), .outReady(outReady), .outSym(outSym),
        .allocError(allocError), .busy(busy), .primaryCarrier(primaryCarrier),
        .fullyConfigured(fullyConfigured), .allocOnPrimary(allocOnPrimary),
        .ulCtrlPresent(ulCtrlPresent), .allocInfoCarriers(allocInfoCarriers),
        .harqFbCarrier(harqFbCarrier), .guard(guard), .guardEnable(guardEnable),
        .guardPrus(guardPrus), .cruFromGuard(cruFromGuard), .guardFault(guardFault));
    msm_far_model u_msm_far_model (.clock(clock), .reset_n(reset_n), .slow(slow),
        .outValid(outValid), .outSym(outSym), .outReady(outReady));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ======
    // Compare and close
    task automatic chk_val(input logic [31:0] exp, input logic [31:0] act);
        num_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, act);
        end
    endtask : chk_val

    task automatic chk_sym(input msm_out_s exp, input msm_out_s act);
        num_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, act);
        end
    endtask : chk_sym

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // ======
    // Descriptor and stream helpers
    function automatic msm_req_s mk(input logic d, input logic [CAR_W-1:0] s,
        input logic [15:0] n, input logic [31:0] b, input logic [31:0] l, input logic [7:0] id);
        return {n, d, s, id[3:0], id[6:4], id, b, l};
    endfunction : mk

    // Next carrier that may carry this descriptor
    function automatic int nxt(input msm_req_s r, input int c);
        for (int i = c + 1; i < NUM_CARRIERS; i++) begin
            if (r.distributed ? r.regionLen[i] != 8'h00 : i == int'(r.singleCarrier)) begin
                return i;
            end
        end
        return NUM_CARRIERS;
    endfunction : nxt

    task automatic put_req(input msm_req_s r);
        reqValid <= 1'b1;
        req <= r;
        do @(posedge clock); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
    endtask : put_req

    task automatic map_pdu(input msm_req_s r);
        msm_out_s e;
        int n;
        int c;
        int u;
        n = int'(r.numSymbols);
        put_req(r);
        for (int i = 0; i < n; i++) begin
            symValid <= 1'b1;
            symData <= 32'h0000_a000 + 32'(i);
            do @(posedge clock); while (symReady !== 1'b1);
            if (i == 0) begin
                chk_val(1'b1, busy);
            end
        end
        symValid <= 1'b0;
        while (u_msm_far_model.got.size() < n) @(posedge clock);
        c = nxt(r, -1);
        u = 0;
        for (int i = 0; i < n; i++) begin
            if (i > 0 && i % UNIT == 0) begin
                u++;
                if (u == int'(r.regionLen[c])) begin
                    c = nxt(r, c);
                    u = 0;
                end
            end
            e = {32'h0000_a000 + 32'(i), CAR_W'(c), r.regionBase[c] + LRU_W'(u),
                TONE_W'(i % UNIT), r.pduId, r.mcs, r.mimo, i == n - 1};
            chk_sym(e, u_msm_far_model.got[i]);
        end
        u_msm_far_model.got.delete();
        chk_val(1'b0, allocError);
    endtask : map_pdu

    // ======
    // Scenarios
    task automatic t_single;
        map_pdu(mk(1'b0, 2'h2, 16'h0032, 32'h0005_0000, 32'h0102_0203, 8'h11));
        chk_val(2'h2, harqFbCarrier);
    endtask : t_single

    task automatic t_split;
        slow <= 1'b1;
        map_pdu(mk(1'b1, 2'h0, 16'h0091, 32'h0a00_0300, 32'h0200_0200, 8'h2c));
        slow <= 1'b0;
        chk_val(2'h0, harqFbCarrier);
        repeat (2) @(posedge clock);
        chk_val(4'ha, allocInfoCarriers);
    endtask : t_split

    task automatic t_err;
        for (int k = 0; k < 2; k++) begin
            put_req(mk(1'b1, 2'h0, k ? 16'h0000 : 16'h0061, 32'h0040_0020, 32'h0001_0001, 8'h5e));
            repeat (2) @(posedge clock);
            chk_val(1'b1, allocError);
            chk_val(1'b1, reqReady);
            chk_val(1'b0, busy);
        end
    endtask : t_err

    task automatic t_edge;
        map_pdu(mk(1'b1, 2'h0, 16'h0060, 32'h0040_0020, 32'h0001_0001, 8'h37));
        chk_val(2'h0, harqFbCarrier);
    endtask : t_edge

    task automatic t_ctrl;
        fullyConfigured <= 4'h6;
        allocOnPrimary <= 1'b1;
        primaryCarrier <= 2'h1;
        repeat (2) @(posedge clock);
        chk_val(4'h6, ulCtrlPresent);
        chk_val(4'h2, allocInfoCarriers);
    endtask : t_ctrl

    task automatic t_guard;
        logic en;
        for (int k = 0; k < 32; k++) begin
            guard <= {k[0], k[1], k[2], k[3], k[4] ? 8'h1e : 8'h24};
            repeat (2) @(posedge clock);
            en = k[0] & k[1] & k[2] & !k[4];
            chk_val(en, guardEnable);
            chk_val(en, cruFromGuard);
            chk_val(k[3] | (k[0] & k[4]), guardFault);
            if (en) begin
                chk_val(4'h2, guardPrus);
            end
        end
    endtask : t_guard

    initial begin
        reset_n = 1'b0;
        reqValid = 1'b0;
        symValid = 1'b0;
        symData = 32'h0000_0000;
        req = '0;
        primaryCarrier = 2'h0;
        fullyConfigured = 4'hf;
        allocOnPrimary = 1'b0;
        guard = '0;
        slow = 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_single();
        t_split();
        t_err();
        t_edge();
        t_ctrl();
        t_guard();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule : tb_top
